// ### tic_counter.sv
// Purpose: Time-of-day timebase with 8-bit interval counter and APB slave
// Assumes: Single 250 MHz clock, synchronous active-high reset
// Notes: pready answers one cycle into the access phase

`timescale 1ns/1ps

module tic_counter #(
    parameter int TICK_DIV = tic_pkg::TICK_CYCLES,
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    // Reject sizes the logic cannot serve, at elaboration
    if (TICK_DIV < 1 || ADDR_W < 10) begin : g_bad_size
        $error("tic_counter: TICK_DIV must be >= 1 and ADDR_W >= 10");
    end
    // Keeps the line count of the old check

    typedef struct packed {
        logic [1:0] sel;
        logic single;
        logic flag;
        logic ien;
        logic ten;
        logic compat;
        logic [7:0] sub;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] cmp;
        logic [7:0] icnt;
        logic [31:0] presc;
        logic irq_stat;
        logic irq_mask;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } tic_state_t;

    tic_state_t r;
    tic_state_t n;

    // Increment with wrap at a top count
    function automatic logic [7:0] tic_inc_wrap(input logic [7:0] v, input logic [7:0] top);
        return (v == top) ? 8'h00 : v + 8'h01;
    endfunction

    function automatic logic tic_mapped(input logic [7:0] idx);
        return idx >= tic_pkg::IDX_CTRL && idx <= tic_pkg::IDX_IRQ_MASK;
    endfunction

    logic [7:0] idx;
    logic acc_wr;
    logic tick;
    logic wrap_sub;
    logic wrap_sec;
    logic wrap_min;
    logic adv;
    logic [7:0] icnt_inc;
    logic match;

    assign idx = paddr[9:2];
    // Write lands only at the edge where pready is sampled high
    assign acc_wr = psel && penable && pwrite && r.pready && tic_mapped(idx);
    // Prescaler tick; nothing moves while the timebase is off
    assign tick = r.ten && (r.presc == 32'(TICK_DIV - 1));
    assign wrap_sub = tick && (r.sub == tic_pkg::SUB_MAX);
    assign wrap_sec = wrap_sub && (r.sec == tic_pkg::SEC_MAX);
    assign wrap_min = wrap_sec && (r.min == tic_pkg::MIN_MAX);
    assign icnt_inc = r.icnt + 8'h01;
    assign match = icnt_inc == r.cmp;

    // Interval advance picked by the base select bits
    always_comb begin
        unique case (r.sel)
            tic_pkg::SEL_SUB: adv = tick;
            tic_pkg::SEL_SEC: adv = wrap_sub;
            tic_pkg::SEL_MIN: adv = wrap_sec;
            tic_pkg::SEL_HOUR: adv = wrap_min;
        endcase
        adv = adv && r.ien;
    end

    // Next state: bus writes first, hardware events after so a set wins over a clear
    always_comb begin
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;

        // Access phase: one wait state, then answer with read data
        if (psel && penable && !r.pready) begin
            n.pready = 1'b1;
            n.pslverr = !tic_mapped(idx);
            n.prdata = 32'h0;
            unique case (idx)
                tic_pkg::IDX_CTRL: n.prdata[7:0] = {1'b0, r.compat, r.sel, r.single,
                                                    r.flag, r.ien, r.ten};
                tic_pkg::IDX_SUB: n.prdata[7:0] = r.sub;
                tic_pkg::IDX_SEC: n.prdata[7:0] = r.sec;
                tic_pkg::IDX_MIN: n.prdata[7:0] = r.min;
                tic_pkg::IDX_HOUR: n.prdata[7:0] = r.hour;
                tic_pkg::IDX_CMP: n.prdata[7:0] = r.cmp;
                tic_pkg::IDX_IRQ_STAT: n.prdata[0] = r.irq_stat;
                tic_pkg::IDX_IRQ_MASK: n.prdata[0] = r.irq_mask;
                default: n.prdata = 32'h0;
            endcase
        end

        // Register writes
        if (acc_wr) begin
            unique case (idx)
                tic_pkg::IDX_CTRL: begin
                    n.ten = pwdata[tic_pkg::CTRL_TEN];
                    n.ien = pwdata[tic_pkg::CTRL_IEN];
                    // Writing zero clears the flag; writing one leaves it
                    n.flag = r.flag && pwdata[tic_pkg::CTRL_FLAG];
                    n.single = pwdata[tic_pkg::CTRL_SINGLE];
                    n.sel = pwdata[tic_pkg::CTRL_SEL_HI:tic_pkg::CTRL_SEL_LO];
                    n.compat = pwdata[tic_pkg::CTRL_COMPAT];
                end
                // Time preset only while stopped, avoids racing the counters
                tic_pkg::IDX_SUB: if (!r.ten) n.sub = pwdata[7:0];
                tic_pkg::IDX_SEC: if (!r.ten) n.sec = pwdata[7:0];
                tic_pkg::IDX_MIN: if (!r.ten) n.min = pwdata[7:0];
                tic_pkg::IDX_HOUR: if (!r.ten) n.hour = pwdata[7:0];
                tic_pkg::IDX_CMP: n.cmp = pwdata[7:0];
                tic_pkg::IDX_IRQ_STAT: n.irq_stat = r.irq_stat && !pwdata[0];
                tic_pkg::IDX_IRQ_MASK: n.irq_mask = pwdata[0];
                default: n.cmp = n.cmp;
            endcase
        end

        // Prescaler for the 1/128 s tick
        if (!r.ten) begin
            n.presc = 32'h0;
        end else if (tick) begin
            n.presc = 32'h0;
        end else begin
            n.presc = r.presc + 32'h1;
        end

        // Time-of-day chain
        if (tick) begin
            n.sub = tic_inc_wrap(r.sub, tic_pkg::SUB_MAX);
        end
        if (wrap_sub) begin
            n.sec = tic_inc_wrap(r.sec, tic_pkg::SEC_MAX);
        end
        if (wrap_sec) begin
            n.min = tic_inc_wrap(r.min, tic_pkg::MIN_MAX);
        end
        if (wrap_min) begin
            n.hour = tic_inc_wrap(r.hour, tic_pkg::HOUR_MAX);
        end

        // Interval counter and timeout
        if (adv) begin
            if (match) begin
                n.flag = 1'b1;
                n.irq_stat = 1'b1;
                n.icnt = 8'h00;
                if (r.single) begin
                    n.ien = 1'b0;
                end
            end else begin
                n.icnt = icnt_inc;
            end
        end
        // Stopped counter holds zero
        if (!n.ien || !n.ten) begin
            n.icnt = 8'h00;
        end

        // Level interrupt, gated by its enable
        n.irq = n.irq_stat && n.irq_mask;
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            r <= '0;
            r.sel <= tic_pkg::RST_SEL;
            r.sub <= tic_pkg::RST_TIME;
            r.sec <= tic_pkg::RST_TIME;
            r.min <= tic_pkg::RST_TIME;
            r.hour <= tic_pkg::RST_TIME;
            r.cmp <= tic_pkg::RST_CMP;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign irq = r.irq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_base_sub;
        tick && r.sel == tic_pkg::SEL_SUB && r.ien |-> adv;
    endproperty
    a_base_sub: assert property (p_base_sub)
        else $error("sub-second base did not advance interval counter");

    property p_single_stop;
        adv && match && r.single |=> !r.ien && r.icnt == 8'h00;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single-shot timeout left interval enabled");

    property p_reload;
        adv && match && !r.single && !acc_wr |=> r.ien && r.icnt == 8'h00;
    endproperty
    a_reload: assert property (p_reload)
        else $error("periodic timeout did not reload");

    property p_flag_set;
        adv && match |=> r.flag && r.irq_stat;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("match did not set interval flag");

    property p_flag_hold;
        r.flag && !acc_wr |=> r.flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("interval flag cleared without a write");

    property p_irq_gate;
        r.irq == (r.irq_stat && r.irq_mask);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while disabled");

    property p_ien_zero;
        !r.ien |-> r.icnt == 8'h00;
    endproperty
    a_ien_zero: assert property (p_ien_zero)
        else $error("interval counter not zero while disabled");

    property p_ten_stop;
        !r.ten && !acc_wr |=> $stable(r.sub) && $stable(r.sec) && r.presc == 32'h0;
    endproperty
    a_ten_stop: assert property (p_ten_stop)
        else $error("time moved with timebase off");

    property p_sub_wrap;
        wrap_sub |=> r.sub == 8'h00 && r.sec != $past(r.sec);
    endproperty
    a_sub_wrap: assert property (p_sub_wrap)
        else $error("sub-second wrap did not bump seconds");

    property p_sec_wrap;
        wrap_sec |=> r.sec == 8'h00 ##0 r.min != $past(r.min);
    endproperty
    a_sec_wrap: assert property (p_sec_wrap)
        else $error("seconds wrap did not bump minutes");

    property p_sub_step;
        tick && r.sub != tic_pkg::SUB_MAX |=> r.sub == $past(r.sub) + 8'h01;
    endproperty
    a_sub_step: assert property (p_sub_step)
        else $error("sub-second did not step on a tick");

    property p_sec_step;
        wrap_sub && r.sec != tic_pkg::SEC_MAX |=> r.sec == $past(r.sec) + 8'h01;
    endproperty
    a_sec_step: assert property (p_sec_step)
        else $error("seconds did not step on a sub-second wrap");

    property p_min_wrap;
        wrap_min |=> r.min == 8'h00 && r.hour != $past(r.hour);
    endproperty
    a_min_wrap: assert property (p_min_wrap)
        else $error("minutes wrap did not bump hours");

    property p_hour_wrap;
        wrap_min && r.hour == tic_pkg::HOUR_MAX |=> r.hour == 8'h00;
    endproperty
    a_hour_wrap: assert property (p_hour_wrap)
        else $error("hours did not wrap after 23");

    property p_preset;
        acc_wr && idx == tic_pkg::IDX_SUB && !r.ten |=> r.sub == $past(pwdata[7:0]);
    endproperty
    a_preset: assert property (p_preset)
        else $error("preset write did not land while stopped");

    property p_preset_block;
        acc_wr && idx == tic_pkg::IDX_SEC && r.ten && !wrap_sub |=> $stable(r.sec);
    endproperty
    a_preset_block: assert property (p_preset_block)
        else $error("time register took a write while running");

    property p_adv_enables;
        adv |-> r.ten && r.ien;
    endproperty
    a_adv_enables: assert property (p_adv_enables)
        else $error("interval counter advanced without both enables");

    property p_sec_base_only;
        r.sel == tic_pkg::SEL_SEC && !wrap_sub |-> !adv;
    endproperty
    a_sec_base_only: assert property (p_sec_base_only)
        else $error("seconds base advanced without a sub-second wrap");

    property p_ien_clear;
        acc_wr && idx == tic_pkg::IDX_CTRL && !pwdata[tic_pkg::CTRL_IEN] |=> !r.ien && r.icnt == 8'h00;
    endproperty
    a_ien_clear: assert property (p_ien_clear)
        else $error("clearing interval enable left the counter running");

    property p_flag_clear;
        acc_wr && idx == tic_pkg::IDX_CTRL && !pwdata[tic_pkg::CTRL_FLAG] && !(adv && match)
            |=> !r.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("software clear of interval flag ignored");

endmodule // tic_counter

// ### tic_pkg.sv
// Purpose: Shared constants for the time interval counter
// Assumes: 250 MHz core clock, APB register access
// Notes: Register offsets are word indices; byte address is four times the index

package tic_pkg;
    // Word indices of the registers
    localparam logic [7:0] IDX_CTRL = 8'ha1;
    localparam logic [7:0] IDX_SUB = 8'ha2;
    localparam logic [7:0] IDX_SEC = 8'ha3;
    localparam logic [7:0] IDX_MIN = 8'ha4;
    localparam logic [7:0] IDX_HOUR = 8'ha5;
    localparam logic [7:0] IDX_CMP = 8'ha6;
    localparam logic [7:0] IDX_IRQ_STAT = 8'ha7;
    localparam logic [7:0] IDX_IRQ_MASK = 8'ha8;

    // Control register field positions
    localparam int CTRL_TEN = 0;
    localparam int CTRL_IEN = 1;
    localparam int CTRL_FLAG = 2;
    localparam int CTRL_SINGLE = 3;
    localparam int CTRL_SEL_LO = 4;
    localparam int CTRL_SEL_HI = 5;
    localparam int CTRL_COMPAT = 6;

    // Values after reset
    localparam logic [7:0] RST_TIME = 8'h00;
    localparam logic [7:0] RST_CMP = 8'h00;
    localparam logic [1:0] RST_SEL = 2'h0;

    // Top counts of the time registers
    localparam logic [7:0] SUB_MAX = 8'h7f;
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] MIN_MAX = 8'h3b;
    localparam logic [7:0] HOUR_MAX = 8'h17;

    // Interval base selections
    localparam logic [1:0] SEL_SUB = 2'h0;
    localparam logic [1:0] SEL_SEC = 2'h1;
    localparam logic [1:0] SEL_MIN = 2'h2;
    localparam logic [1:0] SEL_HOUR = 2'h3;

    // Tick period of 1/128 second and its cycle count at the core rate
    localparam longint TICK_PERIOD_NS = 7812500;
    localparam longint CLK_MHZ = 250;
    localparam int TICK_CYCLES = int'((TICK_PERIOD_NS * CLK_MHZ) / 1000);
endpackage

// ### tb_time_interval_counter.sv
// Purpose: Self-checking bench for the time interval counter
// Assumes: TICK_DIV of 4 so one 1/128 s tick is four core cycles
// Notes: Register access through an APB master task; no random stimulus
`timescale 1ns/1ps

module tb_time_interval_counter;
    typedef struct {logic [7:0] i; logic w; logic [31:0] d; logic [31:0] x; logic e;} tic_row_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int num_errors = 0;
    int n_compared = 0;
    int n;
    int lo;
    logic [31:0] v;
    logic er;
    tic_row_t rows [13] = '{
        '{8'ha6, 1'b1, 32'hff, 32'h0, 1'b0}, '{8'ha6, 1'b0, 32'h0, 32'hff, 1'b0},
        '{8'ha2, 1'b1, 32'h7f, 32'h0, 1'b0}, '{8'ha2, 1'b0, 32'h0, 32'h7f, 1'b0},
        '{8'ha3, 1'b1, 32'h3b, 32'h0, 1'b0}, '{8'ha3, 1'b0, 32'h0, 32'h3b, 1'b0},
        '{8'ha4, 1'b1, 32'h3b, 32'h0, 1'b0}, '{8'ha4, 1'b0, 32'h0, 32'h3b, 1'b0},
        '{8'ha5, 1'b1, 32'h17, 32'h0, 1'b0}, '{8'ha5, 1'b0, 32'h0, 32'h17, 1'b0},
        '{8'ha9, 1'b1, 32'h55, 32'h0, 1'b1}, '{8'ha9, 1'b0, 32'h0, 32'h0, 1'b1},
        '{8'ha1, 1'b1, 32'hc0, 32'h0, 1'b0}};

    tic_counter #(.TICK_DIV(4), .ADDR_W(12)) tic_counter_inst (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));

    // 250 MHz core clock
    always #2 core_clk = ~core_clk;

    task automatic tally_and_finish;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; request held until pready seen, the watchdog bounds the wait
    task automatic apb(input logic [7:0] i, input logic wr, input logic [31:0] d,
                       output logic [31:0] rv, output logic re);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic w(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] rv;
        logic re;
        apb(i, 1'b1, d, rv, re);
    endtask

    task automatic r(input logic [7:0] i, input logic [31:0] e);
        logic [31:0] rv;
        logic re;
        apb(i, 1'b0, 32'h0, rv, re);
        chk($sformatf("reg %h", i), e, rv);
    endtask

    // Cycles until irq rises, capped so a dead interrupt cannot hang
    task automatic wait_irq(input int lim, output int c);
        c = 0;
        while (irq !== 1'b1 && c < lim) begin
            @(posedge core_clk);
            c++;
        end
    endtask

    // Watchdog well beyond the expected run of about 32400 cycles
    initial begin
        #200us;
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        chk("irq in reset", 32'h0, {31'h0, irq});
        reset <= 1'b0;
        @(posedge core_clk);
        for (logic [7:0] k = 8'ha1; k <= 8'ha8; k++) r(k, 32'h0);
        foreach (rows[j]) begin
            apb(rows[j].i, rows[j].w, rows[j].d, v, er);
            if (!rows[j].w) chk("row data", rows[j].x, v);
            chk("row slverr", {31'h0, rows[j].e}, {31'h0, er});
        end
        r(tic_pkg::IDX_CTRL, 32'h40);
        // Full-day wrap from 23:59:59.127, writes ignored while running
        w(tic_pkg::IDX_CTRL, 32'h41);
        repeat (12) @(posedge core_clk);
        w(tic_pkg::IDX_SEC, 32'h05);
        w(tic_pkg::IDX_CTRL, 32'h40);
        r(tic_pkg::IDX_SEC, 32'h0);
        r(tic_pkg::IDX_MIN, 32'h0);
        r(tic_pkg::IDX_HOUR, 32'h0);
        w(tic_pkg::IDX_SUB, 32'h7f);
        repeat (20) @(posedge core_clk);
        r(tic_pkg::IDX_SUB, 32'h7f);
        // Auto-reload at 20 ticks, then mask
        w(tic_pkg::IDX_SUB, 32'h0);
        w(tic_pkg::IDX_CMP, 32'd20);
        w(tic_pkg::IDX_IRQ_MASK, 32'h1);
        w(tic_pkg::IDX_CTRL, 32'h43);
        wait_irq(120, n);
        chk("first timeout", 32'h1, {31'h0, n >= 72 && n <= 88});
        r(tic_pkg::IDX_CTRL, 32'h47);
        w(tic_pkg::IDX_IRQ_STAT, 32'h1);
        w(tic_pkg::IDX_CTRL, 32'h43);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wait_irq(120, n);
        chk("reload timeout", 32'h1, {31'h0, n >= 56 && n <= 76});
        w(tic_pkg::IDX_IRQ_MASK, 32'h0);
        w(tic_pkg::IDX_IRQ_STAT, 32'h1);
        w(tic_pkg::IDX_CTRL, 32'h43);
        repeat (100) @(posedge core_clk);
        chk("masked irq", 32'h0, {31'h0, irq});
        r(tic_pkg::IDX_IRQ_STAT, 32'h1);
        w(tic_pkg::IDX_IRQ_MASK, 32'h1);
        @(posedge core_clk);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        // Single shot stops after one interval
        w(tic_pkg::IDX_CTRL, 32'h40);
        w(tic_pkg::IDX_IRQ_STAT, 32'h1);
        w(tic_pkg::IDX_CMP, 32'd2);
        w(tic_pkg::IDX_CTRL, 32'h4b);
        wait_irq(40, n);
        chk("single timeout", 32'h1, {31'h0, n >= 6 && n <= 10});
        r(tic_pkg::IDX_CTRL, 32'h4d);
        w(tic_pkg::IDX_IRQ_STAT, 32'h1);
        w(tic_pkg::IDX_CTRL, 32'h49);
        repeat (40) @(posedge core_clk);
        chk("one shot idle", 32'h0, {31'h0, irq});
        // Seconds base: one advance per 128 ticks
        w(tic_pkg::IDX_CTRL, 32'h40);
        w(tic_pkg::IDX_SUB, 32'h0);
        w(tic_pkg::IDX_CMP, 32'd1);
        w(tic_pkg::IDX_CTRL, 32'h53);
        wait_irq(600, n);
        chk("second base", 32'h1, {31'h0, n >= 505 && n <= 520});
        // Minute and hour bases; the first carry only reaches the lower bases
        for (int s = 2; s < 4; s++) begin
            w(tic_pkg::IDX_CTRL, 32'h40);
            w(tic_pkg::IDX_IRQ_STAT, 32'h1);
            w(tic_pkg::IDX_SUB, 32'h7f);
            w(tic_pkg::IDX_SEC, (s == 3) ? 32'h3b : 32'h3a);
            w(tic_pkg::IDX_MIN, (s == 3) ? 32'h3a : 32'h0);
            w(tic_pkg::IDX_CTRL, 32'h43 | (s << 4));
            wait_irq((s == 3) ? 31000 : 600, n);
            // 129 ticks to a minute carry, 7681 ticks to an hour carry
            lo = (s == 3) ? 30724 : 516;
            chk("carry base", 32'h1, {31'h0, n >= lo - 4 && n <= lo + 4});
        end
        // Mid-run reset while running returns everything to idle
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk("irq after reset", 32'h0, {31'h0, irq});
        for (logic [7:0] k = 8'ha1; k <= 8'ha8; k++) r(k, 32'h0);
        tally_and_finish();
    end
endmodule // tb_time_interval_counter
